// [core/line_fault_slave.sv]
// serial slave front end with bus-line fault responses
`timescale 1ns/100ps
module line_fault_slave
#(
   parameter int FRAME_LEN = line_fault_pkg::FRAME_BITS
)
(
   // system clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // serial link pins
   input wire logic sclk_in,
   input wire logic select_n_in,
   input wire logic sdi_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   // device status and write path
   input wire logic [line_fault_pkg::STAT_W-1:0] status_in,
   output logic global_fault_flag_out,
   output logic spi_err_out,
   output logic wr_valid_out,
   output line_fault_pkg::write_req_type wr_req_out
);
   import line_fault_pkg::*;

   logic [2:0] sclk_sync_q;
   logic [2:0] sel_sync_q;
   logic sel_stable_q;
   logic sel_fall;
   logic sel_rise;
   logic sclk_stable_q;
   logic sclk_fall;
   logic edge_seen_q;
   logic [LOW_CNT_W-1:0] low_cnt_q;
   logic spi_err_q;
   logic gef_q;
   logic fault_lock_q;
   logic [BYTE_W-1:0] status_snap_q;
   logic clock_violation;
   logic frame_bad_addr;
   logic frame_clear;
   logic frame_write;
   logic [ADDR_W-1:0] frame_addr;
   frame_result_type result_q;
   logic [BIT_CNT_W-1:0] rx_cnt_q;
   logic [BYTE_W-1:0] rx_sr_q;
   logic [BIT_CNT_W-1:0] tx_cnt_q;
   logic tx_bit_q;
   logic started_q;
   logic overrun_q;

   // saturating increment for the bit counters
   function automatic logic [BIT_CNT_W-1:0] sat_inc(input logic [BIT_CNT_W-1:0] v);
      sat_inc = (v == BIT_CNT_MAX) ? v : v + 1'b1;
   endfunction : sat_inc

   // three-stage synchronisers for pin levels
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         sclk_sync_q <= 3'h0;
         sel_sync_q <= 3'h7;
      end
      else
      begin
         sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
         sel_sync_q <= {sel_sync_q[1:0], select_n_in};
      end
   end

   // select edges once stages two and three agree
   assign sel_fall = (sel_sync_q[1] == sel_sync_q[2]) && !sel_sync_q[2] && sel_stable_q;
   assign sel_rise = (sel_sync_q[1] == sel_sync_q[2]) && sel_sync_q[2] && !sel_stable_q;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         sel_stable_q <= 1'b1;
      else if (sel_sync_q[1] == sel_sync_q[2])
         sel_stable_q <= sel_sync_q[2];
   end

   // clock level once stages two and three agree, idle low
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         sclk_stable_q <= 1'b0;
      else if (sclk_sync_q[1] == sclk_sync_q[2])
         sclk_stable_q <= sclk_sync_q[2];
   end

   assign sclk_fall = (sclk_sync_q[1] == sclk_sync_q[2]) && !sclk_sync_q[2] && sclk_stable_q;

   // frame saw a clock pulse; a clockless frame must not reuse old results
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         edge_seen_q <= 1'b0;
      else if (sclk_fall && !sel_stable_q)
         edge_seen_q <= 1'b1;
      else if (sel_fall)
         edge_seen_q <= 1'b0;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         low_cnt_q <= '0;
      else if (sclk_sync_q[1] || sclk_sync_q[2])
         low_cnt_q <= '0;
      else if (low_cnt_q != LOW_CNT_W'(CLOCK_LOW_BEFORE_SELECT_CYC))
         low_cnt_q <= low_cnt_q + 1'b1;
   end

   assign clock_violation = sel_fall &&
      (low_cnt_q < LOW_CNT_W'(CLOCK_LOW_BEFORE_SELECT_CYC));

   // frame decode at select rise, from quiet link registers
   assign frame_addr = result_q.addr[ADDR_W:1];
   // no clock pulse, or without overrun a missing address marker, invalid address or wrong bit count
   assign frame_bad_addr = sel_rise && (!edge_seen_q || (!result_q.overrun &&
      (!result_q.addr[ADDR_MARK_BIT] || frame_addr == INVALID_ADDR ||
       result_q.bits != BIT_CNT_W'(FRAME_LEN))));
   // commands only from a cleanly closed frame
   assign frame_write = sel_rise && edge_seen_q && !result_q.overrun && !frame_bad_addr &&
      result_q.addr[ADDR_OP_BIT];
   assign frame_clear = frame_write && (frame_addr == STATUS_ADDR);

   // error flag, set wins over clear
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         spi_err_q <= 1'b0;
      else if (clock_violation || frame_bad_addr)
         spi_err_q <= 1'b1;
      else if (frame_clear)
         spi_err_q <= 1'b0;
   end

   // sticky constant-one output after a setup violation
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         fault_lock_q <= 1'b0;
      else if (clock_violation)
         fault_lock_q <= 1'b1;
      else if (frame_clear)
         fault_lock_q <= 1'b0;
   end

   // global fault flag from error, faults and power-on state
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         gef_q <= 1'b1;
      else
         gef_q <= spi_err_q || clock_violation || frame_bad_addr ||
            (|(status_in & FAULT_MASK)) || !status_in[NPOR_BIT];
   end

   // status byte snapshot at select fall, LSB always zero
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         status_snap_q <= STATUS_RESET;
      else if (sel_fall)
         status_snap_q <= {spi_err_q || clock_violation, status_in, 1'b0};
   end

   // write requests to the core
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wr_valid_out <= 1'b0;
         wr_req_out <= '0;
      end
      else
      begin
         wr_valid_out <= frame_write && !frame_clear;
         if (frame_write)
            wr_req_out <= '{addr: frame_addr, data: result_q.data};
      end
   end

   assign global_fault_flag_out = gef_q;
   assign spi_err_out = spi_err_q;

   // link domain: sample input on falling clock
   always_ff @(negedge sclk_in or posedge select_n_in)
   begin
      if (select_n_in)
      begin
         rx_cnt_q <= '0;
         rx_sr_q <= '0;
         overrun_q <= 1'b0;
      end
      else
      begin
         rx_cnt_q <= sat_inc(rx_cnt_q);
         rx_sr_q <= {rx_sr_q[BYTE_W-2:0], sdi_in};
         if (rx_cnt_q >= BIT_CNT_W'(FRAME_LEN))
            overrun_q <= 1'b1;
      end
   end

   // frame result kept across select high for the system side
   // clock edges while deselected leave the result alone
   always_ff @(negedge sclk_in)
   begin
      if (!select_n_in)
      begin
         result_q.bits <= sat_inc(rx_cnt_q);
         result_q.overrun <= overrun_q || (rx_cnt_q >= BIT_CNT_W'(FRAME_LEN));
         if (rx_cnt_q == BIT_CNT_W'(BYTE_W - 1))
            result_q.addr <= {rx_sr_q[BYTE_W-2:0], sdi_in};
         if (rx_cnt_q == BIT_CNT_W'(2 * BYTE_W - 1))
            result_q.data <= {rx_sr_q[BYTE_W-2:0], sdi_in};
      end
   end

   // shift out status byte then delayed input, on rising clock
   always_ff @(posedge sclk_in or posedge select_n_in)
   begin
      if (select_n_in)
      begin
         tx_cnt_q <= '0;
         tx_bit_q <= 1'b0;
         started_q <= 1'b0;
      end
      else
      begin
         started_q <= 1'b1;
         tx_cnt_q <= sat_inc(tx_cnt_q);
         if (tx_cnt_q < BIT_CNT_W'(BYTE_W))
            tx_bit_q <= status_snap_q[3'(BYTE_W - 1) - tx_cnt_q[2:0]];
         else
            tx_bit_q <= rx_sr_q[BYTE_W-1];
      end
   end

   // output select: lock, pass-through, pre-clock flag, shifted data
   always_comb
   begin
      if (fault_lock_q)
         sdo_out = 1'b1;
      else if (overrun_q)
         sdo_out = sdi_in;
      else if (!started_q)
         sdo_out = gef_q | sdi_in;
      else
         sdo_out = tx_bit_q;
   end

   assign sdo_oe_out = !select_n_in;
endmodule : line_fault_slave

// [inc/line_fault_pkg.sv]
// shared constants and types for the line-fault-aware serial slave
package line_fault_pkg;
   // system clock period and select setup time
   localparam int CLK_PERIOD_NS = 8;
   localparam int CLOCK_LOW_BEFORE_SELECT_NS = 125;
   // least time rounds up to whole cycles
   localparam int CLOCK_LOW_BEFORE_SELECT_CYC =
      (CLOCK_LOW_BEFORE_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOW_CNT_W = 5;
   // frame layout: address byte then data byte
   localparam int BYTE_W = 8;
   localparam int FRAME_BITS = 16;
   localparam int BIT_CNT_W = 6;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_MAX = 6'h3F;
   // address byte fields
   localparam int ADDR_OP_BIT = 7;
   localparam int ADDR_MARK_BIT = 0;
   localparam int ADDR_W = 6;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h00;
   localparam logic [ADDR_W-1:0] INVALID_ADDR = 6'h3F;
   // status inputs: load, undervolt, overvolt, no-power-on-reset, shutdown, prewarn
   localparam int STAT_W = 6;
   localparam int NPOR_BIT = 2;
   localparam logic [STAT_W-1:0] FAULT_MASK = 6'h3B;
   localparam logic [BYTE_W-1:0] STATUS_RESET = 8'h00;

   // what one frame left behind in the link domain
   typedef struct packed {
      logic [BYTE_W-1:0] addr;
      logic [BYTE_W-1:0] data;
      logic [BIT_CNT_W-1:0] bits;
      logic overrun;
   } frame_result_type;

   // decoded write request toward the core
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [BYTE_W-1:0] data;
   } write_req_type;
endpackage : line_fault_pkg

// [verif/line_fault_asserts.sv]
// assertion checker for the line-fault serial slave
`timescale 1ns/100ps
module line_fault_asserts
import line_fault_pkg::*;
#(parameter int FRAME_LEN = 16)
(
   // clock, reset and link pins
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic select_n_in,
   input wire logic sdi_in,
   input wire logic sdo_out,
   input wire logic sdo_oe_out,
   // status and write path
   input wire logic [STAT_W-1:0] status_in,
   input wire logic global_fault_flag_out,
   input wire logic spi_err_out,
   input wire logic wr_valid_out,
   input wire write_req_type wr_req_out
);
   logic quiet_q;
   logic lock_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // no clock pulse seen since select fell
   always_ff @(posedge clk_in) quiet_q <= select_n_in | (quiet_q & ~sclk_in);
   // clock high at select fall locks output until a clear
   always_ff @(posedge clk_in)
   begin
      if (rst_in || $fell(spi_err_out)) lock_q <= 1'b0;
      else if ($fell(select_n_in) && sclk_in) lock_q <= 1'b1;
   end
   sequence s_fall_hi; $fell(select_n_in) && sclk_in; endsequence
   sequence s_flags; spi_err_out && global_fault_flag_out; endsequence
   property p_oe_off; select_n_in |-> !sdo_oe_out; endproperty
   a_oe_off: assert property (p_oe_off) else $error("oe while idle");
   property p_oe_on; !select_n_in |-> sdo_oe_out; endproperty
   a_oe_on: assert property (p_oe_on) else $error("oe low in frame");
   property p_quiet;
      !select_n_in && quiet_q && !sclk_in |-> sdo_out == (global_fault_flag_out | sdi_in);
   endproperty
   a_quiet: assert property (p_quiet) else $error("sdo not flag or sdi");
   property p_viol; s_fall_hi |-> ##[1:400] s_flags; endproperty
   a_viol: assert property (p_viol) else $error("no flags on clock high");
   property p_lock; $fell(select_n_in) && lock_q |-> sdo_out [*8]; endproperty
   a_lock: assert property (p_lock) else $error("locked sdo not one");
   property p_nowr; wr_valid_out |-> select_n_in && $past(select_n_in, 3); endproperty
   a_nowr: assert property (p_nowr) else $error("write with select low");
   property p_gef; spi_err_out && $past(spi_err_out) |-> global_fault_flag_out; endproperty
   a_gef: assert property (p_gef) else $error("error without fault flag");
   property p_rst;
      $fell(rst_in) |-> global_fault_flag_out && !spi_err_out && !wr_valid_out;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset values");
endmodule : line_fault_asserts
bind line_fault_slave line_fault_asserts #(.FRAME_LEN(FRAME_LEN)) i_chk (.clk_in, .rst_in,
   .sclk_in, .select_n_in, .sdi_in, .sdo_out, .sdo_oe_out, .status_in,
   .global_fault_flag_out, .spi_err_out, .wr_valid_out, .wr_req_out);

// [verif/spi_host.sv]
// host-side serial master model
`timescale 1ns/100ps
module spi_host
(
   // link lines toward the slave
   output logic sclk_out,
   output logic select_n_out,
   output logic sdi_out,
   input wire logic sdo_in
);
   initial
   begin
      sclk_out = 1'b0;
      select_n_out = 1'b1;
      sdi_out = 1'b0;
   end
   // one frame of n clock pulses; hi holds the clock stuck high
   task automatic frame(input logic [15:0] tx, input int n, input bit hi, hold,
      output logic [15:0] rx);
      sclk_out = hi;
      if (select_n_out) #200 select_n_out = 1'b0;
      #81.7;
      for (int i = 15; i >= 0; i--)
      begin
         sdi_out = tx[i];
         sclk_out = hi | (16 - i <= n);
         #80 rx[i] = sdo_in;
         sclk_out = hi;
         #80;
      end
      // released data line drops to its pull-down level; a stuck clock stays put
      sdi_out = 1'b0;
      if (!hold) select_n_out = 1'b1;
   endtask : frame
   // all ones, all zeros or a status byte ending in one is a line fault
   function automatic logic bus_fault(input logic [15:0] v);
      bus_fault = (v == 16'hFFFF) || (v == 16'h0000) || v[8];
   endfunction : bus_fault
endmodule : spi_host

// [verif/tb.sv]
// self-checking bench for the line-fault serial slave
`timescale 1ns/100ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
   $display("mismatch %s exp %h got %h", n, e, a); end end
module tb;
   import line_fault_pkg::*;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [STAT_W-1:0] status_in = 6'h04;
   logic sclk, select_n, sdi, sdo, sdo_oe, global_fault_flag, spi_err, wr_valid;
   write_req_type wr_req;
   logic [15:0] rx;
   int mismatches = 0;
   int cmp_count = 0;
   int writes = 0;
   wire miso = sdo_oe ? sdo : 1'bz;
   // clock and tally of write pulses
   always #4 clk_in = ~clk_in;
   always @(negedge clk_in) if (wr_valid === 1'b1) writes++;
   line_fault_slave i_dut (.clk_in, .rst_in, .sclk_in(sclk), .select_n_in(select_n),
      .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .status_in,
      .global_fault_flag_out(global_fault_flag), .spi_err_out(spi_err), .wr_valid_out(wr_valid),
      .wr_req_out(wr_req));
   spi_host i_host (.sclk_out(sclk), .select_n_out(select_n), .sdi_out(sdi), .sdo_in(miso));
   // one frame, then time for the flags to land
   task automatic go(input logic [15:0] tx, input int n, input bit hi, hold);
      i_host.frame(tx, n, hi, hold, rx);
      repeat (20) @(negedge clk_in);
   endtask : go
   // clear command: write to address zero
   task automatic clr;
      go(16'h8100, 16, 1'b0, 1'b0);
      `CHK("err", 1'b0, spi_err)
   endtask : clr
   task automatic t_write;
      go(16'h8BA5, 16, 1'b0, 1'b0);
      `CHK("rx", 16'h088B, rx)
      `CHK("fault", 1'b0, i_host.bus_fault(rx))
      `CHK("req", 14'h05A5, wr_req)
      `CHK("wr", 1, writes)
   endtask : t_write
   task automatic t_stuck_low;
      go(16'h8BA5, 0, 1'b0, 1'b0);
      `CHK("rx", 16'h8BA5, rx)
      `CHK("fault", 1'b1, i_host.bus_fault(rx))
      `CHK("err", 1'b1, spi_err)
      go(16'h8BA5, 0, 1'b0, 1'b0);
      `CHK("rx", 16'hFFFF, rx)
      `CHK("fault", 1'b1, i_host.bus_fault(rx))
      clr;
   endtask : t_stuck_low
   task automatic t_sdi_open;
      go(16'h0000, 16, 1'b0, 1'b0);
      `CHK("flags", 2'b11, {spi_err, global_fault_flag})
      `CHK("wr", 1, writes)
      clr;
   endtask : t_sdi_open
   task automatic t_clk_high;
      go(16'h8BA5, 16, 1'b1, 1'b0);
      `CHK("flags", 2'b11, {spi_err, global_fault_flag})
      go(16'h8BA5, 16, 1'b0, 1'b0);
      `CHK("rx", 16'hFFFF, rx)
      `CHK("fault", 1'b1, i_host.bus_fault(rx))
      clr;
   endtask : t_clk_high
   task automatic t_sel_low;
      int w = writes;
      go(16'h8BA5, 16, 1'b0, 1'b1);
      go(16'h8B5A, 16, 1'b0, 1'b0);
      `CHK("rx", 15'h0B5A, rx[14:0])
      `CHK("fault", 1'b1, i_host.bus_fault(rx))
      `CHK("wr", w, writes)
      `CHK("oe", 1'b0, sdo_oe)
   endtask : t_sel_low
   // verdict and end of run
   task automatic conclude;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   initial
   begin
      #500000;
      mismatches++;
      conclude;
   end
   initial
   begin
      repeat (16) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (40) @(negedge clk_in);
      t_write;
      t_stuck_low;
      t_sdi_open;
      t_clk_high;
      t_sel_low;
      conclude;
   end
endmodule : tb
